// ### design/supply_supervisor_watchdog.sv
`timescale 1ns/1ps
module supply_supervisor_watchdog #(
    parameter logic [supervisor_pkg::TIMER_W-1:0] RESET_DELAY_CYC = supervisor_pkg::RESET_DELAY_CYC,
    parameter logic [supervisor_pkg::TIMER_W-1:0] WDOG_DEF_CYC    = supervisor_pkg::WDOG_DEF_CYC,
    parameter logic [supervisor_pkg::TIMER_W-1:0] WDOG_PULSE_CYC  = supervisor_pkg::WDOG_PULSE_CYC
) (
    input  wire logic                                   core_clk_in,
    input  wire logic                                   rst_n_in,
    input  wire supervisor_pkg::sense_t                 sense_in,
    input  wire logic [supervisor_pkg::ALT_CFG_W-1:0]   alt_timeout_nf_in,
    output logic                                        reset_n_out,
    output logic                                        reset_out,
    output logic                                        lowline_n_out,
    output logic                                        overvolt_n_out,
    output logic                                        wdog_fault_n_out,
    output logic                                        wdog_pulse_n_out,
    output logic                                        ce_out_n_out,
    output logic                                        early_warn_sense_out,
    output logic                                        early_warn_sense_oe_n_out
);
    localparam int unsigned TW = supervisor_pkg::TIMER_W;

    // ==========================================================
    // reset release and input synchronisation
    logic rst_a_q;
    logic rst_sync_n;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_a_q    <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_a_q    <= 1'b1;
            rst_sync_n <= rst_a_q;
        end
    end

    supervisor_pkg::sense_t s;

    sense_sync #(
        .W       (supervisor_pkg::SENSE_W),
        .RST_VAL (supervisor_pkg::SENSE_RST)
    ) u_sync (
        .clk_in     (core_clk_in),
        .rst_n_in   (rst_sync_n),
        .async_in   (sense_in),
        .stable_out (s)
    );

    // ==========================================================
    // mode selection
    logic mode_ext_q;

    always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode_ext_q <= 1'b0;
        end else if (s.mode_sel_high) begin
            mode_ext_q <= 1'b1;
        end else if (s.mode_sel_low) begin
            mode_ext_q <= 1'b0;
        end
    end

    // ==========================================================
    // reset generation
    wire supply_fail = mode_ext_q ? s.rst_sense_below : s.supply_below;
    wire reset_cond  = supply_fail || !s.manual_reset_n;

    supervisor_pkg::rst_state_t st_q;
    supervisor_pkg::rst_state_t st_d;
    logic                       delay_done;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            supervisor_pkg::RST_ACTIVE: begin
                if (!reset_cond) begin
                    st_d = supervisor_pkg::RST_DELAY;
                end
            end
            supervisor_pkg::RST_DELAY: begin
                if (reset_cond) begin
                    st_d = supervisor_pkg::RST_ACTIVE;
                end else if (delay_done) begin
                    st_d = supervisor_pkg::RST_RUN;
                end
            end
            supervisor_pkg::RST_RUN: begin
                if (reset_cond) begin
                    st_d = supervisor_pkg::RST_ACTIVE;
                end
            end
            default: st_d = supervisor_pkg::RST_ACTIVE;
        endcase
    end

    wire in_reset_d  = (st_d != supervisor_pkg::RST_RUN);
    wire reset_start = (st_q == supervisor_pkg::RST_RUN) && in_reset_d;
    wire reset_end   = !reset_n_out && !in_reset_d;
    wire delay_start = (st_d == supervisor_pkg::RST_DELAY) &&
                       (st_q != supervisor_pkg::RST_DELAY);

    delay_timer u_rst_tmr (
        .clk_in   (core_clk_in),
        .rst_n_in (rst_sync_n),
        .start_in (delay_start),
        .clear_in (reset_cond),
        .len_in   (RESET_DELAY_CYC),
        .busy_out (),
        .done_out (delay_done)
    );

    always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_q        <= supervisor_pkg::RST_ACTIVE;
            reset_n_out <= 1'b0;
            reset_out   <= 1'b1;
        end else begin
            st_q        <= st_d;
            reset_n_out <= !in_reset_d;
            reset_out   <= in_reset_d;
        end
    end

    // ==========================================================
    // low-line, overvoltage and reference pin
    wire lowline_low = mode_ext_q ? s.early_warn_below : s.lowline_below;

    always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            lowline_n_out             <= 1'b1;
            overvolt_n_out            <= 1'b1;
            early_warn_sense_out      <= 1'b0;
            early_warn_sense_oe_n_out <= 1'b1;
        end else begin
            lowline_n_out             <= !lowline_low;
            overvolt_n_out            <= !s.overvolt_above;
            early_warn_sense_out      <= !mode_ext_q;
            early_warn_sense_oe_n_out <= mode_ext_q;
        end
    end

    // ==========================================================
    // watchdog
    logic          kick_prev_q;
    logic          wdog_done;
    logic          lead_done;
    logic          pulse_done;
    wire           kick_edge = (s.wdog_kick != kick_prev_q) && reset_n_out;
    wire [8:0]     alt_k     = s.vcc_3v ? supervisor_pkg::ALT_K3 : supervisor_pkg::ALT_K5;
    wire [TW-1:0]  alt_cyc   = TW'(alt_timeout_nf_in * alt_k * supervisor_pkg::ALT_UNIT_CYC);
    wire [TW-1:0]  wdog_len  = s.timeout_select ? WDOG_DEF_CYC : alt_cyc;
    wire           wdog_arm  = kick_edge || reset_end;

    delay_timer u_wdog_tmr (
        .clk_in   (core_clk_in),
        .rst_n_in (rst_sync_n),
        .start_in (wdog_arm),
        .clear_in (in_reset_d),
        .len_in   (wdog_len),
        .busy_out (),
        .done_out (wdog_done)
    );

    delay_timer u_lead_tmr (
        .clk_in   (core_clk_in),
        .rst_n_in (rst_sync_n),
        .start_in (wdog_done),
        .clear_in (!reset_n_out || kick_edge),
        .len_in   (supervisor_pkg::WDOG_LEAD_CYC),
        .busy_out (),
        .done_out (lead_done)
    );

    delay_timer u_pulse_tmr (
        .clk_in   (core_clk_in),
        .rst_n_in (rst_sync_n),
        .start_in (wdog_done),
        .clear_in (!reset_n_out),
        .len_in   (WDOG_PULSE_CYC),
        .busy_out (),
        .done_out (pulse_done)
    );

    always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            kick_prev_q      <= 1'b0;
            wdog_fault_n_out <= 1'b1;
            wdog_pulse_n_out <= 1'b1;
        end else begin
            kick_prev_q <= s.wdog_kick;
            if (!reset_n_out) begin
                wdog_fault_n_out <= 1'b1;
                wdog_pulse_n_out <= 1'b1;
            end else begin
                if (lead_done) begin
                    wdog_fault_n_out <= 1'b0;
                end else if (kick_edge) begin
                    wdog_fault_n_out <= 1'b1;
                end
                if (wdog_done) begin
                    wdog_pulse_n_out <= 1'b0;
                end else if (pulse_done) begin
                    wdog_pulse_n_out <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // chip-select gating with write completion
    logic ce_hold_q;
    logic ce_hold_done;
    wire  ce_hold_start = reset_start && !s.ce_in_n;

    delay_timer u_ce_tmr (
        .clk_in   (core_clk_in),
        .rst_n_in (rst_sync_n),
        .start_in (ce_hold_start),
        .clear_in (s.ce_in_n),
        .len_in   (supervisor_pkg::CE_HOLD_CYC),
        .busy_out (),
        .done_out (ce_hold_done)
    );

    wire ce_hold_d = !in_reset_d ? 1'b0 :
                     ce_hold_start ? 1'b1 :
                     (ce_hold_q && !ce_hold_done && !s.ce_in_n);
    wire ce_out_d  = in_reset_d ? !ce_hold_d : s.ce_in_n;

    always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ce_hold_q    <= 1'b0;
            ce_out_n_out <= 1'b1;
        end else begin
            ce_hold_q    <= ce_hold_d;
            ce_out_n_out <= ce_out_d;
        end
    end

    // ==========================================================
    // assertions
    localparam int LEAD = int'(supervisor_pkg::WDOG_LEAD_CYC);
    sequence s_fire;
        !wdog_pulse_n_out && wdog_fault_n_out;
    endsequence

    property p_reset_inverse;
        @(posedge core_clk_in) disable iff (!rst_sync_n) reset_out == !reset_n_out;
    endproperty
    a_reset_inverse: assert property (p_reset_inverse)
        else $error("reset outputs not complementary");

    property p_fail_asserts;
        @(posedge core_clk_in) disable iff (!rst_sync_n) supply_fail |=> !reset_n_out;
    endproperty
    a_fail_asserts: assert property (p_fail_asserts)
        else $error("supply fail did not assert reset");

    property p_mr_holds;
        @(posedge core_clk_in) disable iff (!rst_sync_n)
            !s.manual_reset_n |=> !reset_n_out ##1 !reset_n_out;
    endproperty
    a_mr_holds: assert property (p_mr_holds)
        else $error("manual reset did not hold reset");

    property p_release_after_delay;
        @(posedge core_clk_in) disable iff (!rst_sync_n)
            $rose(reset_n_out) |-> $past(delay_done);
    endproperty
    a_release_after_delay: assert property (p_release_after_delay)
        else $error("reset released without delay");

    property p_wdog_quiet;
        @(posedge core_clk_in) disable iff (!rst_sync_n)
            !reset_n_out |=> wdog_fault_n_out && wdog_pulse_n_out;
    endproperty
    a_wdog_quiet: assert property (p_wdog_quiet)
        else $error("watchdog output low during reset");

    property p_pulse_leads;
        @(posedge core_clk_in) disable iff (!rst_sync_n)
            wdog_done && reset_n_out && wdog_fault_n_out |=> s_fire;
    endproperty
    a_pulse_leads: assert property (p_pulse_leads)
        else $error("warning pulse did not lead fault");
    property p_fault_after_pulse;
        @(posedge core_clk_in) disable iff (!rst_sync_n)
            $fell(wdog_fault_n_out) |-> $past(!wdog_pulse_n_out, LEAD);
    endproperty
    a_fault_after_pulse: assert property (p_fault_after_pulse)
        else $error("fault asserted without leading pulse");

    property p_kick_clears;
        @(posedge core_clk_in) disable iff (!rst_sync_n)
            kick_edge && !lead_done |=> wdog_fault_n_out;
    endproperty
    a_kick_clears: assert property (p_kick_clears)
        else $error("kick edge did not clear fault");

    property p_ce_blocked;
        @(posedge core_clk_in) disable iff (!rst_sync_n)
            s.ce_in_n |=> ce_out_n_out;
    endproperty
    a_ce_blocked: assert property (p_ce_blocked)
        else $error("chip select low without request");
    property p_ce_reset_high;
        @(posedge core_clk_in) disable iff (!rst_sync_n)
            !reset_n_out && !ce_hold_q ##1 !reset_n_out |-> ce_out_n_out;
    endproperty
    a_ce_reset_high: assert property (p_ce_reset_high)
        else $error("chip select passed during reset");
    property p_ovo;
        @(posedge core_clk_in) disable iff (!rst_sync_n)
            s.overvolt_above |=> !overvolt_n_out;
    endproperty
    a_ovo: assert property (p_ovo)
        else $error("overvoltage flag not low");
endmodule

// ### design/supervisor_pkg.sv
package supervisor_pkg;

    // ==========================================================
    // clock and cycle arithmetic
    localparam int unsigned     TIMER_W = 40;
    localparam longint unsigned CLK_HZ  = 200_000_000;
    localparam longint unsigned NS_PER_S = 1_000_000_000;

    // round_up for least times, round down for longest times; never below one cycle
    function automatic longint unsigned ns_to_cycles(input longint unsigned ns,
                                                     input bit              round_up);
        longint unsigned prod;
        longint unsigned cyc;
        prod = ns * CLK_HZ;
        cyc  = round_up ? (prod + NS_PER_S - 1) / NS_PER_S : prod / NS_PER_S;
        return (cyc == 0) ? 1 : cyc;
    endfunction

    // ==========================================================
    // documented times
    localparam longint unsigned RESET_DELAY_MS  = 200;
    localparam longint unsigned WDOG_DEF_MS     = 1600;
    localparam longint unsigned WDOG_PULSE_US   = 500;
    localparam longint unsigned WDOG_LEAD_NS    = 70;
    localparam longint unsigned CE_HOLD_US      = 15;
    localparam longint unsigned ALT_UNIT_NS     = 100_000;
    localparam longint unsigned ALT_K5_TENTHS   = 270;
    localparam longint unsigned ALT_K3_TENTHS   = 162;

    localparam logic [TIMER_W-1:0] RESET_DELAY_CYC =
        TIMER_W'(ns_to_cycles(RESET_DELAY_MS * 1_000_000, 1'b0));
    localparam logic [TIMER_W-1:0] WDOG_DEF_CYC =
        TIMER_W'(ns_to_cycles(WDOG_DEF_MS * 1_000_000, 1'b0));
    localparam logic [TIMER_W-1:0] WDOG_PULSE_CYC =
        TIMER_W'(ns_to_cycles(WDOG_PULSE_US * 1_000, 1'b1));
    localparam logic [TIMER_W-1:0] WDOG_LEAD_CYC =
        TIMER_W'(ns_to_cycles(WDOG_LEAD_NS, 1'b0));
    localparam logic [TIMER_W-1:0] CE_HOLD_CYC =
        TIMER_W'(ns_to_cycles(CE_HOLD_US * 1_000, 1'b0));
    localparam logic [TIMER_W-1:0] ALT_UNIT_CYC =
        TIMER_W'(ns_to_cycles(ALT_UNIT_NS, 1'b0));
    localparam logic [8:0]  ALT_K5 = 9'(ALT_K5_TENTHS);
    localparam logic [8:0]  ALT_K3 = 9'(ALT_K3_TENTHS);
    localparam int unsigned ALT_CFG_W = 16;

    // ==========================================================
    // pin and comparator inputs
    typedef struct packed {
        logic supply_below;      // vcc under internal reset threshold
        logic rst_sense_below;   // reset sense under 1.30 V reference
        logic mode_sel_high;     // mode select at or above 600 mV
        logic mode_sel_low;      // mode select at or below 60 mV
        logic lowline_below;     // vcc under internal low-line threshold
        logic early_warn_below;  // early_warn_sense under 1.30 V
        logic overvolt_above;    // overvolt_sense over 1.30 V
        logic manual_reset_n;
        logic wdog_kick;
        logic timeout_select;
        logic vcc_3v;            // selects the 3 V scale factor
        logic ce_in_n;
    } sense_t;

    localparam int unsigned SENSE_W = $bits(sense_t);
    localparam sense_t SENSE_RST = '{manual_reset_n: 1'b1, timeout_select: 1'b1,
                                     ce_in_n: 1'b1, supply_below: 1'b1,
                                     default: 1'b0};

    typedef enum logic [2:0] {
        RST_ACTIVE = 3'b001,
        RST_DELAY  = 3'b010,
        RST_RUN    = 3'b100
    } rst_state_t;

endpackage

// ### design/sense_sync.sv
`timescale 1ns/1ps
// ==========================================================
// three-stage synchroniser; a change is taken once stages two and three agree
module sense_sync #(
    parameter int unsigned          W       = 1,
    parameter logic [W-1:0]         RST_VAL = '0
) (
    input  wire logic               clk_in,
    input  wire logic               rst_n_in,
    input  wire logic [W-1:0]       async_in,
    output logic      [W-1:0]       stable_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    wire  [W-1:0] agree = ~(s2_q ^ s3_q);
    wire  [W-1:0] stable_d = (agree & s3_q) | (~agree & stable_out);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_q       <= RST_VAL;
            s2_q       <= RST_VAL;
            s3_q       <= RST_VAL;
            stable_out <= RST_VAL;
        end else begin
            s1_q       <= async_in;
            s2_q       <= s1_q;
            s3_q       <= s2_q;
            stable_out <= stable_d;
        end
    end
endmodule

// ### design/delay_timer.sv
`timescale 1ns/1ps
// ==========================================================
// one-shot cycle timer: done pulses len cycles after start
module delay_timer (
    input  wire logic                                 clk_in,
    input  wire logic                                 rst_n_in,
    input  wire logic                                 start_in,
    input  wire logic                                 clear_in,
    input  wire logic [supervisor_pkg::TIMER_W-1:0]   len_in,
    output logic                                      busy_out,
    output logic                                      done_out
);
    logic [supervisor_pkg::TIMER_W-1:0] cnt_q;
    wire  expire = busy_out && (cnt_q == '0);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q    <= '0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (clear_in) begin
                busy_out <= 1'b0;
            end else if (start_in) begin
                cnt_q    <= len_in - 1'b1;
                busy_out <= 1'b1;
            end else if (expire) begin
                busy_out <= 1'b0;
                done_out <= 1'b1;
            end else if (busy_out) begin
                cnt_q    <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// ### bench/host_model.sv
`timescale 1ns/1ps
// ==========================================================
// host side: watchdog kicker, reset button, memory chip enable
module host_model (
    input  wire logic       clk_in,
    input  wire logic       kick_en_in,
    input  wire logic [7:0] gap_in,
    input  wire logic       mr_drive_in,
    input  wire logic       mr_val_in,
    input  wire logic       ce_req_in,
    output logic            kick_out,
    output logic            mr_n_out,
    output logic            ce_n_out
);
    logic [7:0] cnt;
    initial begin
        kick_out = 1'b0;
        cnt = 8'h00;
    end
    // toggles the kick every gap+1 cycles, off the sampling edge
    always @(negedge clk_in) begin
        cnt <= (cnt >= gap_in) ? 8'h00 : cnt + 8'h01;
        if (kick_en_in && cnt >= gap_in) begin
            kick_out <= ~kick_out;
        end
    end
    assign mr_n_out = mr_drive_in ? mr_val_in : 1'b1;
    assign ce_n_out = ~ce_req_in;
endmodule

// ### bench/supply_supervisor_watchdog_tb.sv
`timescale 1ns/1ps
module supply_supervisor_watchdog_tb;
    logic                   clk, rst_n, kick_en, mr_drv, mr_val, ce_req, kick, mr_n, ce_n, ext;
    logic                   rn, r, ll_n, ov_n, wf_n, wp_n, ce_o, ew, ew_oe_n;
    logic [7:0]             gap;
    logic [15:0]            nf;
    supervisor_pkg::sense_t s_b, sense;
    int                     err_total, n_tests, n, m, i;
    always_comb begin
        sense = s_b;
        sense.manual_reset_n = mr_n;
        sense.wdog_kick = kick;
        sense.ce_in_n = ce_n;
    end
    host_model u_host_model (.clk_in(clk), .kick_en_in(kick_en), .gap_in(gap),
        .mr_drive_in(mr_drv), .mr_val_in(mr_val), .ce_req_in(ce_req),
        .kick_out(kick), .mr_n_out(mr_n), .ce_n_out(ce_n));
    supply_supervisor_watchdog #(.RESET_DELAY_CYC(40'h14), .WDOG_DEF_CYC(40'h32),
        .WDOG_PULSE_CYC(40'h14)) u_supply_supervisor_watchdog (.core_clk_in(clk),
        .rst_n_in(rst_n), .sense_in(sense), .alt_timeout_nf_in(nf), .reset_n_out(rn),
        .reset_out(r), .lowline_n_out(ll_n), .overvolt_n_out(ov_n), .wdog_fault_n_out(wf_n),
        .wdog_pulse_n_out(wp_n), .ce_out_n_out(ce_o), .early_warn_sense_out(ew),
        .early_warn_sense_oe_n_out(ew_oe_n));
    // ==========================================================
    // checks and helpers
    task automatic chk(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("Error %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: return rn;
            1: return wp_n;
            2: return wf_n;
            default: return ce_o;
        endcase
    endfunction
    function automatic logic exp_ll_n(input logic e, input logic llb, input logic ewb);
        return ~(e ? ewb : llb);
    endfunction
    // counts cycles until output k shows v, bounded by max
    task automatic wait_for(input int k, input logic v, input int max);
        n = 0;
        while (pick(k) !== v && n < max) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(negedge clk);
    endtask
    task automatic end_of_test;
        $display("mismatches %0d, checks %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ==========================================================
    // clock, watchdog, sequence
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #100us;
        err_total++;
        end_of_test();
    end
    initial begin
        {rst_n, kick_en, mr_drv, ce_req, ext} = 5'h00;
        mr_val = 1'b1;
        gap = 8'h0a;
        nf = 16'h0001;
        s_b = supervisor_pkg::SENSE_RST;
        s_b.mode_sel_low = 1'b1;
        err_total = 0;
        n_tests = 0;
        void'($urandom(90));
        cyc(20);
        rst_n = 1'b1;
        cyc(10);
        chk(rn, 1'b0);
        chk(r, 1'b1);
        s_b.supply_below = 1'b0;
        kick_en = 1'b1;
        wait_for(0, 1'b1, 100);
        chk_rng(n, 20, 32);
        chk(r, 1'b0);
        for (i = 0; i < 20; i++) begin
            gap = 8'($urandom_range(2, 30));
            cyc(40);
            chk(wp_n & wf_n, 1'b1);
        end
        kick_en = 1'b0;
        wait_for(1, 1'b0, 100);
        chk(wf_n, 1'b1);
        wait_for(2, 1'b0, 40);
        chk_rng(n, 13, 15);
        m = n;
        wait_for(1, 1'b1, 40);
        chk_rng(m + n, 20, 22);
        cyc(100);
        chk(wf_n, 1'b0);
        chk(wp_n, 1'b1);
        gap = 8'hff;
        kick_en = 1'b1;
        @(kick);
        kick_en = 1'b0;
        wait_for(2, 1'b1, 20);
        chk_rng(n, 2, 8);
        m = n;
        wait_for(1, 1'b0, 100);
        chk_rng(m + n, 50, 60);
        wait_for(1, 1'b1, 40);
        chk_rng(n, 20, 22);
        s_b.timeout_select = 1'b0;
        s_b.vcc_3v = 1'($urandom);
        gap = 8'h05;
        kick_en = 1'b1;
        cyc(20);
        kick_en = 1'b0;
        cyc(200);
        chk(wp_n, 1'b1);
        s_b.timeout_select = 1'b1;
        for (i = 0; i < 16; i++) begin
            ext = i[0];
            s_b.rst_sense_below = 1'b0;
            s_b.mode_sel_high = ext;
            s_b.mode_sel_low = ~ext;
            cyc(6);
            s_b.rst_sense_below = ~ext & 1'($urandom);
            s_b.lowline_below = 1'($urandom);
            s_b.early_warn_below = 1'($urandom);
            s_b.overvolt_above = 1'($urandom);
            ce_req = 1'($urandom);
            cyc(8);
            chk(ll_n, exp_ll_n(ext, s_b.lowline_below, s_b.early_warn_below));
            chk(ov_n, ~s_b.overvolt_above);
            chk(ew_oe_n, ext);
            chk(ew | ext, 1'b1);
            chk(rn, 1'b1);
            chk(ce_o, ~ce_req);
            {s_b.mode_sel_high, s_b.mode_sel_low} = 2'h0;
            cyc(6);
            chk(ew_oe_n, ext);
        end
        s_b.rst_sense_below = 1'b1;
        wait_for(0, 1'b0, 20);
        chk_rng(n, 3, 8);
        s_b.rst_sense_below = 1'b0;
        wait_for(0, 1'b1, 100);
        chk_rng(n, 20, 32);
        wait_for(2, 1'b0, 120);
        chk_rng(n, 60, 70);
        ce_req = 1'b1;
        mr_drv = 1'b1;
        mr_val = 1'b0;
        wait_for(0, 1'b0, 20);
        cyc(5);
        chk(wf_n & wp_n, 1'b1);
        chk(ce_o, 1'b0);
        wait_for(3, 1'b1, 3100);
        chk_rng(n, 2980, 3005);
        ce_req = 1'b0;
        cyc(10);
        ce_req = 1'b1;
        cyc(10);
        chk(ce_o, 1'b1);
        chk(rn, 1'b0);
        mr_val = 1'b1;
        wait_for(0, 1'b1, 100);
        chk_rng(n, 20, 32);
        cyc(3);
        chk(ce_o, 1'b0);
        mr_drv = 1'b0;
        s_b.manual_reset_n = 1'b0;
        cyc(20);
        chk(rn, 1'b1);
        mr_drv = 1'b1;
        mr_val = 1'b0;
        cyc(50);
        ce_req = 1'b0;
        wait_for(3, 1'b1, 20);
        chk_rng(n, 1, 8);
        end_of_test();
    end
endmodule
